// File: pkg/pci_cfg_pkg.sv
// Constants and carriers for the first PCI port identity and command/status bank.
// Assumes one clock domain and full 32-bit word accesses on both ports.
package pci_cfg_pkg;
  localparam logic [11:0] IDENTITY_OFFSET = 12'h000;
  localparam logic [11:0] COMMAND_STATUS_OFFSET = 12'h004;

  // Identity reset values, arbitrary neutral codes
  localparam logic [15:0] DEVICE_IDENTIFIER_RESET = 16'hA5A5;
  localparam logic [15:0] VENDOR_IDENTIFIER_RESET = 16'h5A5A;

  // Identity fields
  localparam int DEVICE_ID_LSB = 16;
  localparam int VENDOR_ID_LSB = 0;

  // Command/status bit positions
  localparam int DETECTED_PARITY_BIT = 31;
  localparam int SIGNALED_SYSTEM_ERROR_BIT = 30;
  localparam int RECEIVED_MASTER_ABORT_BIT = 29;
  localparam int RECEIVED_TARGET_ABORT_BIT = 28;
  localparam int SIGNALED_TARGET_ABORT_BIT = 27;
  localparam int DEVSEL_TIMING_LSB = 25;
  localparam int MASTER_DATA_PARITY_BIT = 24;
  localparam int TARGET_FAST_B2B_BIT = 23;
  localparam int CAPABLE_66MHZ_BIT = 21;
  localparam int CAPABILITIES_LIST_BIT = 20;
  localparam int MASTER_FAST_B2B_BIT = 9;
  localparam int SYSTEM_ERROR_ENABLE_BIT = 8;
  localparam int WAIT_CYCLE_BIT = 7;
  localparam int PARITY_RESPONSE_BIT = 6;
  localparam int BUS_MASTER_BIT = 2;
  localparam int MEMORY_SPACE_BIT = 1;

  // Fixed field values and the enable reset value
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam logic TARGET_FAST_B2B_VALUE = 1'b0;
  localparam logic CAPABLE_66MHZ_VALUE = 1'b1;
  localparam logic MASTER_FAST_B2B_VALUE = 1'b0;
  localparam logic WAIT_CYCLE_VALUE = 1'b0;
  localparam logic ENABLE_RESET = 1'b0;

  // Sticky flag vector, index order
  localparam int FLAG_COUNT = 6;
  localparam int FLAG_MASTER_DATA_PARITY = 0;
  localparam int FLAG_SIGNALED_TARGET_ABORT = 1;
  localparam int FLAG_RECEIVED_TARGET_ABORT = 2;
  localparam int FLAG_RECEIVED_MASTER_ABORT = 3;
  localparam int FLAG_SIGNALED_SYSTEM_ERROR = 4;
  localparam int FLAG_DETECTED_PARITY = 5;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  // Events raised by the transaction engines, one-cycle pulses
  typedef struct packed {
    logic master_data_parity_error;
    logic target_data_parity_error;
    logic target_address_parity_error;
    logic master_abort_received;
    logic target_abort_received;
    logic target_abort_signaled;
    logic addressed_target_perr;
  } pci_events_t;

  // One register port request
  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] offset;
    logic [31:0] wdata;
  } reg_request_t;

  // Loader contents
  typedef struct packed {
    logic load;
    logic [15:0] device_identifier;
    logic [15:0] vendor_identifier;
    logic bus_master_enable;
    logic memory_space_enable;
  } eeprom_load_t;
endpackage

// File: rtl/status_flag_bank.sv
// Bank of sticky status flags; set wins over a simultaneous clear.
// Assumes set and clear are synchronous to clk_sys.
`timescale 1ns/100ps
module status_flag_bank (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Set and clear masks
  input wire logic [pci_cfg_pkg::FLAG_COUNT-1:0] set,
  input wire logic [pci_cfg_pkg::FLAG_COUNT-1:0] clear,
  // Flag state
  output logic [pci_cfg_pkg::FLAG_COUNT-1:0] flags
);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags <= pci_cfg_pkg::FLAGS_RESET;
    end else begin
      flags <= (flags & ~clear) | set;
    end
  end
endmodule

// File: rtl/pci_cfg_id_and_status.sv
// Identity and command/status registers of the first PCI port header.
// Assumes requests and events synchronous to clk_sys, the port clock.
`timescale 1ns/100ps
module pci_cfg_id_and_status (
  // Clock and port reset
  input wire logic clk_sys,
  input wire logic reset,
  // Power-up strap
  input wire logic primary_interface_strap,
  // PCI side register port
  input wire pci_cfg_pkg::reg_request_t pci_request,
  output logic [31:0] pci_rdata,
  // Processor bus side register port
  input wire pci_cfg_pkg::reg_request_t pb_request,
  output logic [31:0] pb_rdata,
  // Loader
  input wire pci_cfg_pkg::eeprom_load_t eeprom,
  // Transaction engine events
  input wire pci_cfg_pkg::pci_events_t events,
  // Controls and signals to the engines
  output logic bus_master_enable,
  output logic memory_space_enable,
  output logic parity_response_enable,
  output logic system_error_report_enable,
  output logic serr_assert,
  output logic perr_assert
);
  logic [15:0] device_identifier;
  logic [15:0] vendor_identifier;
  logic capabilities_list_present;
  logic strap_taken;
  logic [pci_cfg_pkg::FLAG_COUNT-1:0] flags;
  logic [pci_cfg_pkg::FLAG_COUNT-1:0] flag_set;
  logic [pci_cfg_pkg::FLAG_COUNT-1:0] flag_clear;
  logic pci_csr_write;
  logic pb_csr_write;
  logic pb_id_write;
  logic serr_cause;
  logic [31:0] csr_word;
  logic [31:0] id_word;

  function automatic logic [pci_cfg_pkg::FLAG_COUNT-1:0] w1c_mask(input logic [31:0] d);
    logic [pci_cfg_pkg::FLAG_COUNT-1:0] m;
    m = '0;
    m[pci_cfg_pkg::FLAG_MASTER_DATA_PARITY] = d[pci_cfg_pkg::MASTER_DATA_PARITY_BIT];
    m[pci_cfg_pkg::FLAG_SIGNALED_TARGET_ABORT] = d[pci_cfg_pkg::SIGNALED_TARGET_ABORT_BIT];
    m[pci_cfg_pkg::FLAG_RECEIVED_TARGET_ABORT] = d[pci_cfg_pkg::RECEIVED_TARGET_ABORT_BIT];
    m[pci_cfg_pkg::FLAG_RECEIVED_MASTER_ABORT] = d[pci_cfg_pkg::RECEIVED_MASTER_ABORT_BIT];
    m[pci_cfg_pkg::FLAG_SIGNALED_SYSTEM_ERROR] = d[pci_cfg_pkg::SIGNALED_SYSTEM_ERROR_BIT];
    m[pci_cfg_pkg::FLAG_DETECTED_PARITY] = d[pci_cfg_pkg::DETECTED_PARITY_BIT];
    return m;
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] offset, input logic [31:0] idw,
                                            input logic [31:0] csr);
    if (offset == pci_cfg_pkg::IDENTITY_OFFSET) begin
      return idw;
    end else if (offset == pci_cfg_pkg::COMMAND_STATUS_OFFSET) begin
      return csr;
    end
    return 32'h0000_0000;
  endfunction

  assign pci_csr_write = pci_request.write &&
                         pci_request.offset == pci_cfg_pkg::COMMAND_STATUS_OFFSET;
  assign pb_csr_write = pb_request.write &&
                        pb_request.offset == pci_cfg_pkg::COMMAND_STATUS_OFFSET;
  assign pb_id_write = pb_request.write && pb_request.offset == pci_cfg_pkg::IDENTITY_OFFSET;
  // Target address parity reported only with both enables
  assign serr_cause = events.target_address_parity_error && system_error_report_enable &&
                      parity_response_enable;

  always_comb begin
    flag_set = '0;
    flag_set[pci_cfg_pkg::FLAG_DETECTED_PARITY] = events.master_data_parity_error ||
      events.target_data_parity_error || events.target_address_parity_error;
    flag_set[pci_cfg_pkg::FLAG_SIGNALED_SYSTEM_ERROR] = serr_cause;
    flag_set[pci_cfg_pkg::FLAG_RECEIVED_MASTER_ABORT] = events.master_abort_received;
    flag_set[pci_cfg_pkg::FLAG_RECEIVED_TARGET_ABORT] = events.target_abort_received;
    flag_set[pci_cfg_pkg::FLAG_SIGNALED_TARGET_ABORT] = events.target_abort_signaled;
    flag_set[pci_cfg_pkg::FLAG_MASTER_DATA_PARITY] = parity_response_enable &&
      (events.master_data_parity_error || events.addressed_target_perr);
    // Only ones clear; zeros leave flags alone
    flag_clear = (pci_csr_write ? w1c_mask(pci_request.wdata) : '0) |
                 (pb_csr_write ? w1c_mask(pb_request.wdata) : '0);
  end

  status_flag_bank flag_bank (
    .clk_sys(clk_sys),
    .reset(reset),
    .set(flag_set),
    .clear(flag_clear),
    .flags(flags)
  );

  // Identity: processor writes only, PCI writes dropped
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      device_identifier <= pci_cfg_pkg::DEVICE_IDENTIFIER_RESET;
      vendor_identifier <= pci_cfg_pkg::VENDOR_IDENTIFIER_RESET;
    end else if (pb_id_write) begin
      device_identifier <= pb_request.wdata[pci_cfg_pkg::DEVICE_ID_LSB +: 16];
      vendor_identifier <= pb_request.wdata[pci_cfg_pkg::VENDOR_ID_LSB +: 16];
    end else if (eeprom.load) begin
      device_identifier <= eeprom.device_identifier;
      vendor_identifier <= eeprom.vendor_identifier;
    end
  end

  // Command enables; processor write wins over PCI write
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bus_master_enable <= pci_cfg_pkg::ENABLE_RESET;
      memory_space_enable <= pci_cfg_pkg::ENABLE_RESET;
      parity_response_enable <= pci_cfg_pkg::ENABLE_RESET;
      system_error_report_enable <= pci_cfg_pkg::ENABLE_RESET;
    end else if (pb_csr_write || pci_csr_write) begin
      bus_master_enable <= pb_csr_write ? pb_request.wdata[pci_cfg_pkg::BUS_MASTER_BIT]
                                        : pci_request.wdata[pci_cfg_pkg::BUS_MASTER_BIT];
      memory_space_enable <= pb_csr_write ? pb_request.wdata[pci_cfg_pkg::MEMORY_SPACE_BIT]
                                          : pci_request.wdata[pci_cfg_pkg::MEMORY_SPACE_BIT];
      parity_response_enable <= pb_csr_write ?
        pb_request.wdata[pci_cfg_pkg::PARITY_RESPONSE_BIT] :
        pci_request.wdata[pci_cfg_pkg::PARITY_RESPONSE_BIT];
      system_error_report_enable <= pb_csr_write ?
        pb_request.wdata[pci_cfg_pkg::SYSTEM_ERROR_ENABLE_BIT] :
        pci_request.wdata[pci_cfg_pkg::SYSTEM_ERROR_ENABLE_BIT];
    end else if (eeprom.load) begin
      bus_master_enable <= eeprom.bus_master_enable;
      memory_space_enable <= eeprom.memory_space_enable;
    end
  end

  // Strap caught on first edge after reset release
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strap_taken <= 1'b0;
      capabilities_list_present <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      capabilities_list_present <= primary_interface_strap;
    end
  end

  // Error signalling pulses to the bus drivers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      serr_assert <= 1'b0;
      perr_assert <= 1'b0;
    end else begin
      serr_assert <= serr_cause;
      perr_assert <= parity_response_enable &&
        (events.master_data_parity_error || events.target_data_parity_error);
    end
  end

  always_comb begin
    id_word = {device_identifier, vendor_identifier};
    csr_word = 32'h0000_0000;
    csr_word[pci_cfg_pkg::DETECTED_PARITY_BIT] = flags[pci_cfg_pkg::FLAG_DETECTED_PARITY];
    csr_word[pci_cfg_pkg::SIGNALED_SYSTEM_ERROR_BIT] =
      flags[pci_cfg_pkg::FLAG_SIGNALED_SYSTEM_ERROR];
    csr_word[pci_cfg_pkg::RECEIVED_MASTER_ABORT_BIT] =
      flags[pci_cfg_pkg::FLAG_RECEIVED_MASTER_ABORT];
    csr_word[pci_cfg_pkg::RECEIVED_TARGET_ABORT_BIT] =
      flags[pci_cfg_pkg::FLAG_RECEIVED_TARGET_ABORT];
    csr_word[pci_cfg_pkg::SIGNALED_TARGET_ABORT_BIT] =
      flags[pci_cfg_pkg::FLAG_SIGNALED_TARGET_ABORT];
    csr_word[pci_cfg_pkg::DEVSEL_TIMING_LSB +: 2] = pci_cfg_pkg::DEVSEL_MEDIUM;
    csr_word[pci_cfg_pkg::MASTER_DATA_PARITY_BIT] = flags[pci_cfg_pkg::FLAG_MASTER_DATA_PARITY];
    csr_word[pci_cfg_pkg::TARGET_FAST_B2B_BIT] = pci_cfg_pkg::TARGET_FAST_B2B_VALUE;
    csr_word[pci_cfg_pkg::CAPABLE_66MHZ_BIT] = pci_cfg_pkg::CAPABLE_66MHZ_VALUE;
    csr_word[pci_cfg_pkg::CAPABILITIES_LIST_BIT] = capabilities_list_present;
    csr_word[pci_cfg_pkg::MASTER_FAST_B2B_BIT] = pci_cfg_pkg::MASTER_FAST_B2B_VALUE;
    csr_word[pci_cfg_pkg::SYSTEM_ERROR_ENABLE_BIT] = system_error_report_enable;
    csr_word[pci_cfg_pkg::WAIT_CYCLE_BIT] = pci_cfg_pkg::WAIT_CYCLE_VALUE;
    csr_word[pci_cfg_pkg::PARITY_RESPONSE_BIT] = parity_response_enable;
    csr_word[pci_cfg_pkg::BUS_MASTER_BIT] = bus_master_enable;
    csr_word[pci_cfg_pkg::MEMORY_SPACE_BIT] = memory_space_enable;
  end

  // Read data registered, one cycle after the read strobe
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pci_rdata <= 32'h0000_0000;
      pb_rdata <= 32'h0000_0000;
    end else begin
      if (pci_request.read) begin
        pci_rdata <= read_word(pci_request.offset, id_word, csr_word);
      end
      if (pb_request.read) begin
        pb_rdata <= read_word(pb_request.offset, id_word, csr_word);
      end
    end
  end

  sequence s_master_abort;
    events.master_abort_received;
  endsequence
  sequence s_no_clear_rma;
    !flag_clear[pci_cfg_pkg::FLAG_RECEIVED_MASTER_ABORT] [*3];
  endsequence

  property p_id_pci_write_ignored;
    @(posedge clk_sys) disable iff (reset)
      pci_request.write && !pb_id_write && !eeprom.load |=> $stable(id_word);
  endproperty
  a_id_pci_write_ignored: assert property (p_id_pci_write_ignored)
    else $error("identity changed on a PCI-side write");

  property p_detected_parity;
    @(posedge clk_sys) disable iff (reset)
      events.target_address_parity_error |=> csr_word[pci_cfg_pkg::DETECTED_PARITY_BIT];
  endproperty
  a_detected_parity: assert property (p_detected_parity)
    else $error("detected parity flag not set");

  property p_serr_needs_enables;
    @(posedge clk_sys) disable iff (reset)
      serr_assert |-> $past(system_error_report_enable) && $past(parity_response_enable) &&
        csr_word[pci_cfg_pkg::SIGNALED_SYSTEM_ERROR_BIT];
  endproperty
  a_serr_needs_enables: assert property (p_serr_needs_enables)
    else $error("system error signalled without both enables");

  property p_master_abort_sticky;
    @(posedge clk_sys) disable iff (reset)
      s_master_abort ##1 s_no_clear_rma |-> flags[pci_cfg_pkg::FLAG_RECEIVED_MASTER_ABORT];
  endproperty
  a_master_abort_sticky: assert property (p_master_abort_sticky)
    else $error("received master abort flag did not hold");

  property p_set_beats_clear;
    @(posedge clk_sys) disable iff (reset)
      events.target_abort_received && pb_csr_write |=>
        flags[pci_cfg_pkg::FLAG_RECEIVED_TARGET_ABORT];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("target abort event lost against a clear");

  property p_fixed_fields;
    @(posedge clk_sys) disable iff (reset)
      pb_request.read && pb_request.offset == pci_cfg_pkg::COMMAND_STATUS_OFFSET |=>
        pb_rdata[pci_cfg_pkg::DEVSEL_TIMING_LSB +: 2] == 2'h1 &&
        pb_rdata[pci_cfg_pkg::CAPABLE_66MHZ_BIT] && !pb_rdata[pci_cfg_pkg::WAIT_CYCLE_BIT] &&
        !pb_rdata[pci_cfg_pkg::TARGET_FAST_B2B_BIT];
  endproperty
  a_fixed_fields: assert property (p_fixed_fields)
    else $error("fixed command/status fields read wrong");

  property p_mdp_gated;
    @(posedge clk_sys) disable iff (reset)
      $rose(flags[pci_cfg_pkg::FLAG_MASTER_DATA_PARITY]) |-> $past(parity_response_enable);
  endproperty
  a_mdp_gated: assert property (p_mdp_gated)
    else $error("master data parity flag set with parity response off");

  property p_zero_write_keeps;
    @(posedge clk_sys) disable iff (reset)
      pci_csr_write && !pb_csr_write && pci_request.wdata[31:24] == 8'h00 |=>
        flags[pci_cfg_pkg::FLAG_SIGNALED_TARGET_ABORT] >=
        $past(flags[pci_cfg_pkg::FLAG_SIGNALED_TARGET_ABORT]);
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps)
    else $error("zero write cleared a status flag");

  property p_perr_gated;
    @(posedge clk_sys) disable iff (reset)
      perr_assert |-> $past(parity_response_enable);
  endproperty
  a_perr_gated: assert property (p_perr_gated)
    else $error("PERR driven with parity response off");
endmodule

// File: tb/event_source_model.sv
// Behavioural transaction engines: turn a numbered trigger into one event pulse.
// Assumes trigger and kind change just after rising edges of clk_sys.
`timescale 1ns/100ps
module event_source_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Trigger from the bench
  input wire logic trigger,
  input wire logic [2:0] kind,
  // Events toward the bank
  output pci_cfg_pkg::pci_events_t events
);
  logic [6:0] pulse;

  // One pulse per trigger, bit 0 is the last struct field
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pulse <= 7'h00;
    end else if (trigger) begin
      pulse <= 7'h01 << kind;
    end else begin
      pulse <= 7'h00;
    end
  end

  assign events = pci_cfg_pkg::pci_events_t'(pulse);
endmodule

// File: tb/tb_pci_cfg_id_and_status.sv
// Self-checking bench for the identity and command/status bank.
// Assumes the design's fixed one-cycle read latency and next-edge event response.
`timescale 1ns/100ps
module tb_pci_cfg_id_and_status;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic strap = 1'b1;
  logic trigger = 1'b0;
  logic [2:0] kind = 3'h0;
  pci_cfg_pkg::reg_request_t pci_req = '0;
  pci_cfg_pkg::reg_request_t pb_req = '0;
  pci_cfg_pkg::eeprom_load_t eeprom = '0;
  pci_cfg_pkg::pci_events_t events;
  logic [31:0] pci_rdata;
  logic [31:0] pb_rdata;
  logic bme, mse, pre, sre, serr, perr;
  int fails = 0;
  int comparisons = 0;
  localparam logic [31:0] BASE = 32'h0230_0146;
  localparam logic [31:0] FLAG_EXP [7] = '{32'h0100_0000, 32'h0800_0000, 32'h1000_0000,
    32'h2000_0000, 32'hC000_0000, 32'h8000_0000, 32'h8100_0000};

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  event_source_model partner (.clk_sys(clk_sys), .reset(reset), .trigger(trigger),
    .kind(kind), .events(events));

  pci_cfg_id_and_status dut (.clk_sys(clk_sys), .reset(reset),
    .primary_interface_strap(strap), .pci_request(pci_req), .pci_rdata(pci_rdata),
    .pb_request(pb_req), .pb_rdata(pb_rdata), .eeprom(eeprom), .events(events),
    .bus_master_enable(bme), .memory_space_enable(mse), .parity_response_enable(pre),
    .system_error_report_enable(sre), .serr_assert(serr), .perr_assert(perr));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One word access on either port; read data taken one cycle later
  task automatic acc(input bit pb, input bit wr, input logic [11:0] off,
                     input logic [31:0] d, output logic [31:0] rd);
    pci_cfg_pkg::reg_request_t r;
    r = '{read: ~wr, write: wr, offset: off, wdata: d};
    @(posedge clk_sys);
    if (pb) begin
      pb_req <= r;
    end else begin
      pci_req <= r;
    end
    @(posedge clk_sys);
    pb_req <= '0;
    pci_req <= '0;
    @(negedge clk_sys);
    rd = pb ? pb_rdata : pci_rdata;
  endtask

  task automatic wr(input bit pb, input logic [11:0] off, input logic [31:0] d);
    logic [31:0] dummy;
    acc(pb, 1'b1, off, d, dummy);
  endtask

  task automatic rd_chk(input bit pb, input logic [11:0] off, input logic [31:0] exp);
    logic [31:0] v;
    acc(pb, 1'b0, off, 32'h0000_0000, v);
    check(v, exp);
  endtask

  // Event pulse from the partner; returns once the bank has taken it
  task automatic fire(input logic [2:0] k);
    @(posedge clk_sys);
    trigger <= 1'b1;
    kind <= k;
    @(posedge clk_sys);
    trigger <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    finish_test();
  end

  initial begin
    logic [31:0] v;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    // Reset state seen from both ports
    rd_chk(1'b0, 12'h000, {pci_cfg_pkg::DEVICE_IDENTIFIER_RESET,
      pci_cfg_pkg::VENDOR_IDENTIFIER_RESET});
    rd_chk(1'b1, 12'h004, 32'h0230_0000);
    check({bme, mse, pre, sre}, 32'h0000_0000);
    // Loader, then identity writes from each side
    @(posedge clk_sys);
    eeprom <= '{load: 1'b1, device_identifier: 16'h1357, vendor_identifier: 16'h2468,
      bus_master_enable: 1'b1, memory_space_enable: 1'b1};
    @(posedge clk_sys);
    eeprom <= '0;
    rd_chk(1'b0, 12'h000, 32'h1357_2468);
    check({bme, mse}, 32'h0000_0003);
    wr(1'b0, 12'h000, 32'hFFFF_FFFF);
    rd_chk(1'b1, 12'h000, 32'h1357_2468);
    wr(1'b1, 12'h000, 32'h1234_5678);
    rd_chk(1'b0, 12'h000, 32'h1234_5678);
    // All ones into command/status: only enables stick
    wr(1'b0, 12'h004, 32'hFFFF_FFFF);
    rd_chk(1'b1, 12'h004, BASE);
    check({bme, mse, pre, sre}, 32'h0000_000F);
    // Unmapped offset
    wr(1'b1, 12'h008, 32'hFFFF_FFFF);
    rd_chk(1'b1, 12'h008, 32'h0000_0000);
    // Every event kind with both enables on
    for (int k = 0; k < 7; k++) begin
      fire(k[2:0]);
      check(serr, (k == 4) ? 32'h1 : 32'h0);
      check(perr, (k >= 5) ? 32'h1 : 32'h0);
      acc(1'b1, 1'b0, 12'h004, 32'h0000_0000, v);
      check(v, BASE | FLAG_EXP[k]);
      wr(1'b0, 12'h004, 32'h0000_0146);
      rd_chk(1'b1, 12'h004, BASE | FLAG_EXP[k]);
      wr(1'b1, 12'h004, FLAG_EXP[k] | 32'hC000_0146);
      rd_chk(1'b0, 12'h004, BASE);
    end
    // Event against a clear, both ports writing in the same cycle
    @(posedge clk_sys);
    trigger <= 1'b1;
    kind <= 3'h2;
    @(posedge clk_sys);
    trigger <= 1'b0;
    pb_req <= '{read: 1'b0, write: 1'b1, offset: 12'h004, wdata: 32'h1000_0146};
    pci_req <= '{read: 1'b0, write: 1'b1, offset: 12'h004, wdata: 32'h0000_0000};
    @(posedge clk_sys);
    pb_req <= '0;
    pci_req <= '0;
    rd_chk(1'b1, 12'h004, BASE | FLAG_EXP[2]);
    check({bme, mse, pre, sre}, 32'h0000_000F);
    // Parity response off: no master parity flag, no SERR
    wr(1'b1, 12'h004, 32'h1000_0100);
    fire(3'h6);
    check(perr, 32'h0000_0000);
    rd_chk(1'b1, 12'h004, 32'h8230_0100);
    wr(1'b1, 12'h004, 32'h8000_0100);
    fire(3'h4);
    check(serr, 32'h0000_0000);
    rd_chk(1'b0, 12'h004, 32'h8230_0100);
    // Mid-run reset with the strap low
    @(posedge clk_sys);
    reset <= 1'b1;
    strap <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(1'b1, 12'h004, 32'h0220_0000);
    rd_chk(1'b0, 12'h000, {pci_cfg_pkg::DEVICE_IDENTIFIER_RESET,
      pci_cfg_pkg::VENDOR_IDENTIFIER_RESET});
    check({bme, mse, pre, sre}, 32'h0000_0000);
    finish_test();
  end
endmodule
